// ===== external_move_instruction_steer_pkg.sv
package external_move_instruction_steer_pkg;

	// Register addresses on the special-function bus. Two registers share one address.
	localparam logic [7:0] ADDR_PROGRAM_STORE_CONTROL = 8'h8F;
	localparam logic [7:0] ADDR_FLASH_LIMIT_HIGH_BYTE = 8'hB7;
	localparam logic [7:0] ADDR_FLASH_TIMING_WRITE_CONTROL = 8'hB7;
	localparam logic [7:0] ADDR_EXT_PAGE_HIGH_BYTE = 8'hA2;
	localparam logic [7:0] ADDR_EXT_INTERFACE_CONFIG = 8'hA3;
	// Page select that picks between the two registers at the shared address.
	localparam logic [7:0] ADDR_PAGE_SELECT = 8'h84;
	localparam logic [7:0] PAGE_LIMIT = 8'h0F;

	// Reset values.
	localparam logic [7:0] RST_PROGRAM_STORE_CONTROL = 8'h00;
	localparam logic [7:0] RST_FLASH_LIMIT_HIGH_BYTE = 8'h00;
	localparam logic [7:0] RST_FLASH_TIMING_WRITE_CONTROL = 8'h80;
	localparam logic [7:0] RST_EXT_PAGE_HIGH_BYTE = 8'h00;
	localparam logic [7:0] RST_EXT_INTERFACE_CONFIG = 8'h03;
	localparam logic [7:0] RST_PAGE_SELECT = 8'h00;

	// Field positions.
	localparam int BIT_ONESHOT = 7;
	localparam int BIT_READ_EVERY = 6;
	localparam int BIT_GLOBAL_WE = 0;
	localparam int BIT_SCRATCH = 2;
	localparam int BIT_PAGE_ERASE = 1;
	localparam int BIT_PROG_WE = 0;
	localparam int BIT_PORT_SELECT = 5;
	localparam int BIT_MODE_HI = 3;
	localparam int BIT_MODE_LO = 2;
	// Writable masks; other bits read as zero.
	localparam logic [7:0] MASK_TIMING = 8'hC1;
	localparam logic [7:0] MASK_PROGRAM_STORE_CONTROL = 8'h07;
	localparam logic [7:0] MASK_EXTCFG = 8'h3F;

	// Memory geometry.
	localparam logic [15:0] ONCHIP_RAM_BYTES = 16'h1000;
	localparam logic [15:0] SCRATCH_MASK = 16'h007F;
	localparam logic [15:0] LOCK_PAGE_BASE = 16'hFC00;
	localparam int PAGE_SHIFT = 9;

	// One-shot sense amplifier hold time, in ns, and its cycle count at 20 MHz.
	localparam int ONESHOT_NS = 100;
	localparam int CLOCK_NS = 50;
	localparam int ONESHOT_CYCLES = (ONESHOT_NS + CLOCK_NS - 1) / CLOCK_NS;

	// Memory modes of the external data space.
	typedef enum logic [1:0] {
		MODE_INTERNAL = 2'b00,
		MODE_SPLIT_NOBANK = 2'b01,
		MODE_SPLIT_BANK = 2'b10,
		MODE_EXTERNAL = 2'b11
	} mem_mode_type;

	// One move request from the core.
	typedef struct packed {
		logic valid;
		logic write;
		logic wide;
		logic [15:0] pointer;
		logic [7:0] index;
		logic [7:0] wdata;
		logic [15:0] code_pc;
	} move_req_type;

	// One flash operation toward the array.
	typedef struct packed {
		logic read;
		logic write;
		logic erase;
		logic scratch;
		logic [15:0] addr;
		logic [7:0] wdata;
	} flash_op_type;

endpackage

// ===== external_move_instruction_flash_xram_steering.sv
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
module external_move_instruction_flash_xram_steering (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	input wire external_move_instruction_steer_pkg::move_req_type move_in,
	input wire logic [7:0] flash_rdata_in,
	input wire logic [7:0] ext_rdata_in,
	output external_move_instruction_steer_pkg::flash_op_type flash_op_out,
	output logic sense_amp_on_out,
	output logic [7:0] move_rdata_out,
	output logic move_done_out,
	output logic ram_sel_out,
	output logic ram_write_out,
	output logic [11:0] ram_addr_out,
	output logic [7:0] ram_wdata_out,
	output logic [15:0] ext_addr_out,
	output logic ext_addr_high_oe_out,
	output logic ext_addr_low_oe_out,
	output logic [7:0] ext_data_out,
	output logic ext_data_oe_out,
	output logic ext_read_strobe_out,
	output logic ext_write_strobe_out,
	output logic high_ports_claim_out,
	output logic low_ports_claim_out
);

	// Software-visible registers, then internal state and decode signals.
	logic [7:0] timing_r;
	logic [7:0] program_store_control_r;
	logic [7:0] limit_r;
	logic limit_locked_r;
	logic [7:0] page_r;
	logic [7:0] extcfg_r;
	logic [7:0] sfr_page_r;
	logic [$clog2(external_move_instruction_steer_pkg::ONESHOT_CYCLES + 1) - 1:0] oneshot_r;
	logic [15:0] eff_addr;
	logic [15:0] limit_addr;
	logic protected_hit;
	logic offchip;
	logic drive_high;
	external_move_instruction_steer_pkg::mem_mode_type mode;
	logic [7:0] rd_nxt;

	// Shared addresses decode by the page select register.
	always_comb begin
		rd_nxt = 8'h00;
		unique case (reg_addr_in)
			external_move_instruction_steer_pkg::ADDR_PROGRAM_STORE_CONTROL: rd_nxt = program_store_control_r;
			external_move_instruction_steer_pkg::ADDR_FLASH_LIMIT_HIGH_BYTE: begin
				// Reserved bits of the control register are held at zero.
				rd_nxt = (sfr_page_r == external_move_instruction_steer_pkg::PAGE_LIMIT) ? limit_r : timing_r;
			end
			external_move_instruction_steer_pkg::ADDR_EXT_PAGE_HIGH_BYTE: rd_nxt = page_r;
			external_move_instruction_steer_pkg::ADDR_EXT_INTERFACE_CONFIG: rd_nxt = extcfg_r;
			external_move_instruction_steer_pkg::ADDR_PAGE_SELECT: rd_nxt = sfr_page_r;
			default: rd_nxt = 8'h00;
		endcase
	end

	// Register writes; limit writes lock after the first one.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			timing_r <= external_move_instruction_steer_pkg::RST_FLASH_TIMING_WRITE_CONTROL;
			program_store_control_r <= external_move_instruction_steer_pkg::RST_PROGRAM_STORE_CONTROL;
			limit_r <= external_move_instruction_steer_pkg::RST_FLASH_LIMIT_HIGH_BYTE;
			limit_locked_r <= 1'b0;
			page_r <= external_move_instruction_steer_pkg::RST_EXT_PAGE_HIGH_BYTE;
			extcfg_r <= external_move_instruction_steer_pkg::RST_EXT_INTERFACE_CONFIG;
			sfr_page_r <= external_move_instruction_steer_pkg::RST_PAGE_SELECT;
		end else if (reg_write_in) begin
			unique case (reg_addr_in)
				external_move_instruction_steer_pkg::ADDR_PROGRAM_STORE_CONTROL: begin
					program_store_control_r <= reg_wdata_in & external_move_instruction_steer_pkg::MASK_PROGRAM_STORE_CONTROL;
				end
				external_move_instruction_steer_pkg::ADDR_FLASH_LIMIT_HIGH_BYTE: begin
					if (sfr_page_r == external_move_instruction_steer_pkg::PAGE_LIMIT) begin
						if (!limit_locked_r) begin
							limit_r <= reg_wdata_in;
							limit_locked_r <= 1'b1;
						end
					end else begin
						timing_r <= reg_wdata_in & external_move_instruction_steer_pkg::MASK_TIMING;
					end
				end
				external_move_instruction_steer_pkg::ADDR_EXT_PAGE_HIGH_BYTE: page_r <= reg_wdata_in;
				external_move_instruction_steer_pkg::ADDR_EXT_INTERFACE_CONFIG: begin
					extcfg_r <= reg_wdata_in & external_move_instruction_steer_pkg::MASK_EXTCFG;
				end
				external_move_instruction_steer_pkg::ADDR_PAGE_SELECT: sfr_page_r <= reg_wdata_in;
				default: begin
				end
			endcase
		end
	end

	// Read data stands in the cycle after the strobe only.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			reg_rdata_out <= reg_read_in ? rd_nxt : 8'h00;
		end
	end

	// Effective address: full pointer or page byte with index.
	always_comb begin
		if (move_in.wide) begin
			eff_addr = move_in.pointer;
		end else begin
			eff_addr = {page_r, move_in.index};
		end
	end

	// Limit address and the protected-partition check.
	assign limit_addr = {limit_r, 8'h00};
	assign protected_hit = (move_in.code_pc >= limit_addr) && (eff_addr < limit_addr);
	assign mode = external_move_instruction_steer_pkg::mem_mode_type'(extcfg_r[external_move_instruction_steer_pkg::BIT_MODE_HI:
		external_move_instruction_steer_pkg::BIT_MODE_LO]);

	// Off-chip decision by memory mode.
	always_comb begin
		unique case (mode)
			external_move_instruction_steer_pkg::MODE_INTERNAL: offchip = 1'b0;
			external_move_instruction_steer_pkg::MODE_EXTERNAL: offchip = 1'b1;
			default: offchip = (eff_addr >= external_move_instruction_steer_pkg::ONCHIP_RAM_BYTES);
		endcase
		drive_high = move_in.wide || (mode == external_move_instruction_steer_pkg::MODE_SPLIT_BANK);
	end

	// Flash operations: writes, erases and sense amplifier reads.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flash_op_out <= '0;
		end else begin
			flash_op_out <= '0;
			flash_op_out.read <= timing_r[external_move_instruction_steer_pkg::BIT_READ_EVERY];
			flash_op_out.scratch <= program_store_control_r[external_move_instruction_steer_pkg::BIT_SCRATCH];
			if (move_in.valid && move_in.write && program_store_control_r[external_move_instruction_steer_pkg::BIT_PROG_WE]) begin
				flash_op_out.addr <= program_store_control_r[external_move_instruction_steer_pkg::BIT_SCRATCH] ?
					(eff_addr & external_move_instruction_steer_pkg::SCRATCH_MASK) : eff_addr;
				flash_op_out.wdata <= move_in.wdata;
				if (timing_r[external_move_instruction_steer_pkg::BIT_GLOBAL_WE] && !protected_hit) begin
					if (program_store_control_r[external_move_instruction_steer_pkg::BIT_PAGE_ERASE]) begin
						// The lock-byte page is never erased.
						flash_op_out.erase <= program_store_control_r[external_move_instruction_steer_pkg::BIT_SCRATCH] ||
							((eff_addr >> external_move_instruction_steer_pkg::PAGE_SHIFT) !=
							(external_move_instruction_steer_pkg::LOCK_PAGE_BASE >> external_move_instruction_steer_pkg::PAGE_SHIFT));
					end else begin
						flash_op_out.write <= 1'b1;
					end
				end
			end
		end
	end

	// One-shot timer turns the sense amplifiers off after a read.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			oneshot_r <= '0;
			sense_amp_on_out <= 1'b0;
		end else begin
			if (flash_op_out.read || flash_op_out.write || flash_op_out.erase) begin
				oneshot_r <= ($bits(oneshot_r))'(external_move_instruction_steer_pkg::ONESHOT_CYCLES);
			end else if (oneshot_r != '0) begin
				oneshot_r <= oneshot_r - 1'b1;
			end
			// With the timer disabled the amplifiers stay on.
			sense_amp_on_out <= !timing_r[external_move_instruction_steer_pkg::BIT_ONESHOT] || (oneshot_r != '0);
		end
	end

	// Data-space access: on-chip RAM or the external pins.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ram_sel_out <= 1'b0;
			ram_write_out <= 1'b0;
			ram_addr_out <= 12'h000;
			ram_wdata_out <= 8'h00;
			ext_addr_out <= 16'h0000;
			ext_addr_high_oe_out <= 1'b0;
			ext_addr_low_oe_out <= 1'b0;
			ext_data_out <= 8'h00;
			ext_data_oe_out <= 1'b0;
			ext_read_strobe_out <= 1'b0;
			ext_write_strobe_out <= 1'b0;
			high_ports_claim_out <= 1'b0;
			low_ports_claim_out <= 1'b0;
		end else begin
			ram_sel_out <= 1'b0;
			ram_write_out <= 1'b0;
			ext_addr_high_oe_out <= 1'b0;
			ext_addr_low_oe_out <= 1'b0;
			ext_data_oe_out <= 1'b0;
			ext_read_strobe_out <= 1'b0;
			ext_write_strobe_out <= 1'b0;
			high_ports_claim_out <= 1'b0;
			low_ports_claim_out <= 1'b0;
			// Program-store writes never reach the data space.
			if (move_in.valid && !(move_in.write && program_store_control_r[external_move_instruction_steer_pkg::BIT_PROG_WE])) begin
				if (!offchip) begin
					ram_sel_out <= 1'b1;
					ram_write_out <= move_in.write;
					ram_addr_out <= eff_addr[11:0];
					ram_wdata_out <= move_in.wdata;
				end else begin
					// Pins are claimed for this move only.
					high_ports_claim_out <= extcfg_r[external_move_instruction_steer_pkg::BIT_PORT_SELECT];
					low_ports_claim_out <= !extcfg_r[external_move_instruction_steer_pkg::BIT_PORT_SELECT];
					ext_addr_out <= eff_addr;
					ext_addr_low_oe_out <= 1'b1;
					ext_addr_high_oe_out <= drive_high;
					// Data drivers only on writes; output mode stays with ports.
					ext_data_oe_out <= move_in.write;
					ext_data_out <= move_in.wdata;
					ext_read_strobe_out <= !move_in.write;
					ext_write_strobe_out <= move_in.write;
				end
			end
		end
	end

	// Read answer: external data when off-chip, else flash data; zero when protected.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			move_rdata_out <= 8'h00;
			move_done_out <= 1'b0;
		end else begin
			move_done_out <= move_in.valid;
			if (protected_hit) begin
				move_rdata_out <= 8'h00;
			end else begin
				move_rdata_out <= offchip ? ext_rdata_in : flash_rdata_in;
			end
		end
	end

	// Only one limit write may land per reset.
	chk_limit_write_once: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		limit_locked_r |=> $stable(limit_r)) else $error("limit changed twice");

	// Flash change requires global enable.
	chk_global_enable_gate: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		(flash_op_out.write || flash_op_out.erase) |-> $past(timing_r[0]))
		else $error("flash change without enable");

	// Protected reads return zero.
	chk_protected_read_zero: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		protected_hit |=> move_rdata_out == 8'h00) else $error("protected data leaked");

	// Input data pins never driven.
	chk_read_no_drive: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		ext_read_strobe_out |-> !ext_data_oe_out) else $error("driver on input pin");

	// Pins claimed only with a strobe.
	chk_claim_with_move: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		(high_ports_claim_out || low_ports_claim_out) |->
		(ext_read_strobe_out || ext_write_strobe_out)) else $error("idle claim");

	// Reserved bits stay zero.
	chk_reserved_zero: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		timing_r[5:1] == 5'b00000) else $error("reserved bits set");

	// Writes with program write enable reach neither RAM nor the external pins.
	chk_write_to_flash: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		(move_in.valid && move_in.write && program_store_control_r[0]) |=> !ram_write_out && !ext_write_strobe_out)
		else $error("flash write leaked");

	// The two port groups are never claimed together.
	chk_port_select: assert property (@(posedge clock_in) disable iff (!rst_b_in)
		high_ports_claim_out |-> !low_ports_claim_out) else $error("both groups");

endmodule // external_move_instruction_flash_xram_steering
`default_nettype wire

// ===== external_move_instruction_ext_memory_model.sv
`timescale 1ns/10ps
`default_nettype none
// Off-chip byte memory on the port pins; the core presents its lookup address early.
module external_move_instruction_ext_memory_model (
	input wire logic clock_in,
	input wire logic [15:0] ext_addr_out,
	input wire logic [7:0] ext_data_out,
	input wire logic ext_write_strobe_out,
	input wire logic [15:0] req_addr_in,
	input wire logic req_read_in,
	output logic [7:0] ext_rdata_in
);
	logic [7:0] mem_r [256]; // Storage, indexed by the low address byte.
	logic [7:0] last_r = 8'h00; // Last value driven, inverted while idle.
	// Fill with a pattern so a stale bus cannot pass for real data.
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem_r[i] = 8'(i) ^ 8'hC3;
		end
	end
	// Store on the write strobe; the released bus shows the inverse of the last value.
	always @(posedge clock_in) begin
		if (ext_write_strobe_out) begin
			mem_r[ext_addr_out[7:0]] <= ext_data_out;
		end
		if (req_read_in) begin
			last_r <= mem_r[req_addr_in[7:0]];
		end
	end
	assign ext_rdata_in = req_read_in ? mem_r[req_addr_in[7:0]] : ~last_r;
endmodule // external_move_instruction_ext_memory_model
`default_nettype wire

// ===== external_move_instruction_flash_xram_steering_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// Bench: register rows first, then hand-written move cases.
module external_move_instruction_flash_xram_steering_tb_top;
	typedef struct packed {logic rd; logic [7:0] a; logic [7:0] d;} row_type; // Bus row.
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, v;
	logic reg_write_in = 1'b0, reg_read_in = 1'b0, req_read_in = 1'b0;
	logic [15:0] req_addr_in = 16'h0000;
	external_move_instruction_steer_pkg::move_req_type move_in = '0;
	logic [7:0] flash_rdata_in = 8'h00, ext_rdata_in, move_rdata_out, ram_wdata_out, ext_data_out;
	external_move_instruction_steer_pkg::flash_op_type flash_op_out;
	logic sense_amp_on_out, move_done_out, ram_sel_out, ram_write_out, ext_data_oe_out;
	logic [11:0] ram_addr_out;
	logic [15:0] ext_addr_out;
	logic ext_addr_high_oe_out, ext_addr_low_oe_out, ext_read_strobe_out, ext_write_strobe_out;
	logic high_ports_claim_out, low_ports_claim_out;
	int mismatches = 0, tests_run = 0, cycles = 0;
	// Reset values, reserved bits, then the write-once limit register.
	row_type rows [19] = '{'{1'b1, 8'h8F, 8'h00}, '{1'b1, 8'hB7, 8'h80}, '{1'b1, 8'hA2, 8'h00},
		'{1'b1, 8'hA3, 8'h03}, '{1'b1, 8'h55, 8'h00}, '{1'b0, 8'hB7, 8'hFF}, '{1'b1, 8'hB7, 8'hC1},
		'{1'b0, 8'h8F, 8'hFF}, '{1'b1, 8'h8F, 8'h07}, '{1'b0, 8'hA3, 8'hFF}, '{1'b1, 8'hA3, 8'h3F},
		'{1'b0, 8'h84, 8'h0F}, '{1'b0, 8'hB7, 8'h40}, '{1'b0, 8'hB7, 8'h20}, '{1'b1, 8'hB7, 8'h40},
		'{1'b0, 8'h84, 8'h00}, '{1'b0, 8'hB7, 8'h81}, '{1'b0, 8'h8F, 8'h00}, '{1'b1, 8'hB7, 8'h81}};
	external_move_instruction_flash_xram_steering i_dut (.clock_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
		.reg_write_in, .reg_read_in, .reg_rdata_out, .move_in, .flash_rdata_in, .ext_rdata_in,
		.flash_op_out, .sense_amp_on_out, .move_rdata_out, .move_done_out, .ram_sel_out,
		.ram_write_out, .ram_addr_out, .ram_wdata_out, .ext_addr_out, .ext_addr_high_oe_out,
		.ext_addr_low_oe_out, .ext_data_out, .ext_data_oe_out, .ext_read_strobe_out,
		.ext_write_strobe_out, .high_ports_claim_out, .low_ports_claim_out);
	external_move_instruction_ext_memory_model i_mem (.clock_in, .ext_addr_out, .ext_data_out, .ext_write_strobe_out,
		.req_addr_in, .req_read_in, .ext_rdata_in);
	// Free-running 20 MHz clock.
	initial begin
		forever #25 clock_in = ~clock_in;
	end
	// Cuts a hang short.
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			final_report();
		end
	end
	// Compares one observed value with its expectation.
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_write_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask
	// One-cycle register read; data stand in the following cycle.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_in);
		reg_read_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask
	// One move request; outputs are sampled in the cycle after it.
	task automatic mv(input logic w, input logic wide, input logic [15:0] p, input logic [15:0] ea,
			input logic [15:0] pc, input logic [7:0] ix, input logic [7:0] d);
		@(posedge clock_in);
		move_in <= '{valid: 1'b1, write: w, wide: wide, pointer: p, index: ix, wdata: d, code_pc: pc};
		req_addr_in <= ea;
		req_read_in <= ~w;
		flash_rdata_in <= ~d;
		@(posedge clock_in);
		move_in <= '0;
		req_read_in <= 1'b0;
		#1;
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (20) @(posedge clock_in);
		rst_b_in <= 1'b1;
		chk("done idle", move_done_out, 16'h0000);
		foreach (rows[i]) begin
			if (rows[i].rd) begin
				rd(rows[i].a, v);
				chk("register", v, rows[i].d);
			end else begin
				wr(rows[i].a, rows[i].d);
			end
		end
		// Software configures ports and modes before moving; high ports, external only.
		wr(8'hA3, 8'h2C);
		mv(1'b0, 1'b1, 16'h1234, 16'h1234, 16'h0000, 8'h00, 8'h00);
		chk("ext addr", ext_addr_out, 16'h1234);
		chk("addr oe wide", {ext_addr_high_oe_out, ext_addr_low_oe_out}, 16'h0003);
		chk("high claim", {high_ports_claim_out, low_ports_claim_out}, 16'h0002);
		chk("read strobe", {ext_read_strobe_out, move_done_out}, 16'h0003);
		chk("data oe read", ext_data_oe_out, 16'h0000);
		chk("read data", move_rdata_out, 16'h00F7);
		@(posedge clock_in);
		#1;
		chk("claim released", high_ports_claim_out, 16'h0000);
		// Low ports need the crossbar skip; split mode with bank select, short form.
		wr(8'hA3, 8'h08);
		wr(8'hA2, 8'h56);
		mv(1'b1, 1'b0, 16'h0000, 16'h5678, 16'h0000, 8'h78, 8'hA5);
		chk("short addr", ext_addr_out, 16'h5678);
		chk("addr oe bank", {ext_addr_high_oe_out, ext_addr_low_oe_out}, 16'h0003);
		chk("low claim", {high_ports_claim_out, low_ports_claim_out}, 16'h0001);
		chk("write out", {ext_write_strobe_out, ext_data_oe_out, ext_data_out}, 16'h03A5);
		mv(1'b0, 1'b0, 16'h0000, 16'h5678, 16'h0000, 8'h78, 8'h00);
		chk("read back", move_rdata_out, 16'h00A5);
		// Internal only: on-chip RAM takes the move.
		wr(8'hA3, 8'h00);
		mv(1'b1, 1'b1, 16'h0123, 16'h0123, 16'h0000, 8'h00, 8'h3C);
		chk("ram", {ram_sel_out, ram_write_out, ram_addr_out}, 16'h3123);
		chk("ram data", ram_wdata_out, 16'h003C);
		chk("ram idle pins", low_ports_claim_out, 16'h0000);
		// Program write enable without the global enable changes nothing.
		wr(8'h8F, 8'h01);
		wr(8'hB7, 8'h80);
		mv(1'b1, 1'b1, 16'h5000, 16'h5000, 16'h6000, 8'h00, 8'h3C);
		chk("no flash write", {flash_op_out.write, flash_op_out.erase, ram_write_out}, 16'h0000);
		// Both enables: the write goes to flash, below the limit only for low code.
		wr(8'hB7, 8'h81);
		mv(1'b1, 1'b1, 16'h5000, 16'h5000, 16'h6000, 8'h00, 8'h3C);
		chk("flash write", {flash_op_out.write, flash_op_out.addr[14:0]}, 16'hD000);
		chk("read as needed", flash_op_out.read, 16'h0000);
		chk("flash wstrobe", {flash_op_out.write, ram_write_out, flash_op_out.wdata}, 16'h023C);
		mv(1'b1, 1'b1, 16'h1000, 16'h1000, 16'h6000, 8'h00, 8'h3C);
		chk("protected", flash_op_out.write, 16'h0000);
		mv(1'b1, 1'b1, 16'h1000, 16'h1000, 16'h0100, 8'h00, 8'h3C);
		chk("low code write", flash_op_out.write, 16'h0001);
		// Page erase, then the lock page that software may never erase.
		wr(8'h8F, 8'h03);
		mv(1'b1, 1'b1, 16'h5010, 16'h5010, 16'h6000, 8'h00, 8'h00);
		chk("erase", {flash_op_out.erase, flash_op_out.write}, 16'h0002);
		mv(1'b1, 1'b1, 16'hFC10, 16'hFC10, 16'h6000, 8'h00, 8'h00);
		chk("lock page", flash_op_out.erase, 16'h0000);
		// Scratchpad select redirects an in-range flash write.
		wr(8'h8F, 8'h05);
		mv(1'b1, 1'b1, 16'h0010, 16'h0010, 16'h0000, 8'h00, 8'h11);
		chk("scratch", {flash_op_out.scratch, flash_op_out.write}, 16'h0003);
		// Read-always with the one-shot off keeps the amplifiers on.
		wr(8'hB7, 8'h40);
		@(posedge clock_in);
		#1;
		chk("read always", {flash_op_out.read, sense_amp_on_out}, 16'h0003);
		// One-shot back on with no reads: the timer runs out and the amplifiers turn off.
		wr(8'hB7, 8'h80);
		repeat (5) @(posedge clock_in);
		#1;
		chk("oneshot off", {flash_op_out.read, sense_amp_on_out}, 16'h0000);
		// A reset in mid-run makes the limit register writable once more.
		@(posedge clock_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		rst_b_in <= 1'b1;
		wr(8'h84, 8'h0F);
		rd(8'hB7, v);
		chk("limit after reset", v, 16'h0000);
		wr(8'hB7, 8'h12);
		wr(8'hB7, 8'h34);
		rd(8'hB7, v);
		chk("limit rewritten", v, 16'h0012);
		final_report();
	end
endmodule // external_move_instruction_flash_xram_steering_tb_top
`default_nettype wire
